// ==== logic/cfg_defines.svh ====
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

// configuration dword byte addresses
`define CFG_CMD_OFFSET 8'h04
`define CFG_REV_OFFSET 8'h08
`define CFG_CLASS_OFFSET 8'h09
`define CFG_CLASS_BASE_OFFSET 8'h0B
`define CFG_CLASS_SUB_OFFSET 8'h0A
`define CFG_CLASS_PIF_OFFSET 8'h09

// command field positions
`define CMD_IO_SPACE_BIT 0
`define CMD_MEM_SPACE_BIT 1
`define CMD_BUS_MASTER_BIT 2
`define CMD_MWI_BIT 4
`define CMD_SNOOP_BIT 5
`define CMD_SERR_BIT 8
`define CMD_WRITABLE_MASK 16'h0137
`define CMD_RESET_VALUE 16'h0000

// class code and its byte fields
`define CLASS_CODE_VALUE 24'h030000
`define REV_LSB 0
`define CLASS_LSB 8

// vga decode ranges
`define VGA_IO_MONO_LO 10'h3B0
`define VGA_IO_MONO_HI 10'h3BB
`define VGA_IO_COLOR_LO 10'h3C0
`define VGA_IO_COLOR_HI 10'h3DF
`define VGA_MEM_A0000 32'h000A0000
`define VGA_MEM_B0000 32'h000B0000
`define VGA_MEM_B8000 32'h000B8000
`define VGA_MEM_C0000 32'h000C0000

`endif

// ==== logic/cfg_pkg.sv ====
package cfg_pkg;
    typedef enum logic [1:0] {
        MAP_A0000_128K = 2'b00,
        MAP_A0000_64K = 2'b01,
        MAP_B0000_32K = 2'b10,
        MAP_B8000_32K = 2'b11
    } vga_mem_map_e;

    typedef enum logic [3:0] {
        BUS_CMD_MEM_WRITE = 4'h7,
        BUS_CMD_MEM_WRITE_INV = 4'hF
    } bus_write_cmd_e;
endpackage : cfg_pkg

// ==== logic/cfg_vga_io_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cfg_defines.svh"

module cfg_vga_io_decode (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic io_space_en,
    input wire logic io_cycle,
    input wire logic [15:0] io_addr,
    output logic io_hit
);
    logic [9:0] low_addr;
    logic in_range;

    // upper bits ignored so every alias of the vga ports matches
    assign low_addr = io_addr[9:0];
    assign in_range = (low_addr >= `VGA_IO_MONO_LO &&
                       low_addr <= `VGA_IO_MONO_HI) ||
                      (low_addr >= `VGA_IO_COLOR_LO &&
                       low_addr <= `VGA_IO_COLOR_HI);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            io_hit <= 1'b0;
        end else begin
            io_hit <= io_cycle && io_space_en && in_range; // R7
        end
    end
endmodule : cfg_vga_io_decode
`default_nettype wire

// ==== logic/cfg_vga_mem_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cfg_defines.svh"

module cfg_vga_mem_decode (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic mem_space_en,
    input wire logic mem_cycle,
    input wire logic [31:0] mem_addr,
    input wire logic [7:0] bar0_base,
    input wire logic [7:0] bar1_base,
    input wire logic [1:0] vga_graphics_misc_reg,
    input wire logic vga_mem_en,
    output logic mem_bar_hit,
    output logic mem_vga_hit
);
    logic [31:0] win_lo;
    logic [31:0] win_hi;
    logic vga_in;
    logic bar_in;

    // window follows the memory map field, not a fixed range
    always_comb begin
        unique case (cfg_pkg::vga_mem_map_e'(vga_graphics_misc_reg))
            cfg_pkg::MAP_A0000_128K: begin
                win_lo = `VGA_MEM_A0000;
                win_hi = `VGA_MEM_C0000;
            end
            cfg_pkg::MAP_A0000_64K: begin
                win_lo = `VGA_MEM_A0000;
                win_hi = `VGA_MEM_B0000;
            end
            cfg_pkg::MAP_B0000_32K: begin
                win_lo = `VGA_MEM_B0000;
                win_hi = `VGA_MEM_B8000;
            end
            cfg_pkg::MAP_B8000_32K: begin
                win_lo = `VGA_MEM_B8000;
                win_hi = `VGA_MEM_C0000;
            end
        endcase
    end

    assign vga_in = vga_mem_en && mem_addr >= win_lo && mem_addr < win_hi; // R6
    // 16 mbyte ranges: only the top address byte is compared
    assign bar_in = (mem_addr[31:24] == bar0_base) ||
                    (mem_addr[31:24] == bar1_base);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mem_bar_hit <= 1'b0;
            mem_vga_hit <= 1'b0;
        end else begin
            mem_bar_hit <= mem_cycle && mem_space_en && bar_in; // R5
            mem_vga_hit <= mem_cycle && mem_space_en && vga_in; // R5
        end
    end
endmodule : cfg_vga_mem_decode
`default_nettype wire

// ==== logic/pci_config_command_class_rev.sv ====
// Summary of operation
// R1 - system error pin driven only while command bit 8 is set; resets 0.
// R2 - command bit 5 turns on palette snooping; read-write, resets 0.
// R3 - memory write and invalidate allowed only with command bit 4 set.
// R4 - no initiator transactions while command bit 2 is clear.
// R5 - command bit 1 gates memory decode of base ranges and vga window.
// R6 - vga memory window follows graphics misc field bits 3:2 and enables.
// R7 - command bit 0 gates vga io ports 3B0-3BB, 3C0-3DF and aliases.
// R8 - class code sits in bits 31:8 as base, sub-class, interface bytes.
// R9 - class code reads as 030000, a vga compatible display controller.
// R10 - revision in bits 7:0 is read-only, a vendor chosen value.
// R11 - reserved command bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_defines.svh"

module pci_config_command_class_rev #(
    // arbitrary neutral revision value
    parameter logic [7:0] SILICON_REVISION = 8'h5A
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // configuration cycle port
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    // system error pin, open drain
    input wire logic serr_req,
    output logic serr_n_o,
    output logic serr_n_oe_n,
    // bus master requests from the engines
    input wire logic master_req,
    input wire logic master_wants_mwi,
    output logic master_req_out,
    output logic [3:0] master_write_cmd,
    output logic palette_snoop_en,
    // target decode
    input wire logic mem_cycle,
    input wire logic [31:0] mem_addr,
    input wire logic [7:0] bar0_base,
    input wire logic [7:0] bar1_base,
    input wire logic [1:0] vga_graphics_misc_reg,
    input wire logic vga_mem_en,
    output logic mem_bar_hit,
    output logic mem_vga_hit,
    input wire logic io_cycle,
    input wire logic [15:0] io_addr,
    output logic io_hit
);
    logic [15:0] bus_command_control_q;
    logic [15:0] bus_command_control_d;
    logic [15:0] be_mask;
    logic [31:0] rdata_d;
    logic sel_cmd;
    logic sel_rev;
    logic [23:0] function_class;
    logic [7:0] silicon_revision;
    logic system_error_driver_en;
    logic mem_write_invalidate_en;
    logic bus_master_en;
    logic mem_space_en;
    logic io_space_en;

    ////////////////////////////////////////////////////////////////////
    // address decode and read-only identity

    assign sel_cmd = (cfg_addr[7:2] == 6'(`CFG_CMD_OFFSET >> 2));
    // class bytes 09..0B share the dword with the revision byte
    assign sel_rev = (cfg_addr[7:2] == 6'(`CFG_REV_OFFSET >> 2));
    assign function_class = `CLASS_CODE_VALUE; // R9
    assign silicon_revision = SILICON_REVISION; // R10

    ////////////////////////////////////////////////////////////////////
    // command register

    assign be_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};

    always_comb begin
        bus_command_control_d = bus_command_control_q;
        if (cfg_wr && sel_cmd) begin
            // reserved bits never latch a one
            bus_command_control_d = (bus_command_control_q & ~be_mask) |
                (cfg_wdata[15:0] & be_mask & `CMD_WRITABLE_MASK); // R11
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bus_command_control_q <= `CMD_RESET_VALUE;
        end else begin
            bus_command_control_q <= bus_command_control_d;
        end
    end

    assign system_error_driver_en = bus_command_control_q[`CMD_SERR_BIT];
    assign palette_snoop_en = bus_command_control_q[`CMD_SNOOP_BIT]; // R2
    assign mem_write_invalidate_en = bus_command_control_q[`CMD_MWI_BIT];
    assign bus_master_en = bus_command_control_q[`CMD_BUS_MASTER_BIT];
    assign mem_space_en = bus_command_control_q[`CMD_MEM_SPACE_BIT];
    assign io_space_en = bus_command_control_q[`CMD_IO_SPACE_BIT];

    ////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        rdata_d = 32'h00000000;
        if (sel_cmd) begin
            // status half lives elsewhere and reads zero here
            rdata_d[15:0] = bus_command_control_q; // R11
        end else if (sel_rev) begin
            rdata_d[`CLASS_LSB +: 24] = function_class; // R8
            rdata_d[`REV_LSB +: 8] = silicon_revision; // R10
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_rdata <= 32'h00000000;
        end else if (cfg_rd) begin
            cfg_rdata <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_ack <= 1'b0;
        end else begin
            cfg_ack <= cfg_rd || cfg_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // system error driver and master gating

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            serr_n_oe_n <= 1'b1;
        end else begin
            // pin only ever pulled low, so oe alone carries the event
            serr_n_oe_n <= ~(serr_req && system_error_driver_en); // R1
        end
    end
    assign serr_n_o = 1'b0;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            master_req_out <= 1'b0;
        end else begin
            master_req_out <= master_req && bus_master_en; // R4
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            master_write_cmd <= cfg_pkg::BUS_CMD_MEM_WRITE;
        end else if (master_wants_mwi && mem_write_invalidate_en) begin
            master_write_cmd <= cfg_pkg::BUS_CMD_MEM_WRITE_INV; // R3
        end else begin
            master_write_cmd <= cfg_pkg::BUS_CMD_MEM_WRITE; // R3
        end
    end

    ////////////////////////////////////////////////////////////////////
    // target decoders

    cfg_vga_mem_decode u_mem_decode (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .mem_space_en(mem_space_en),
        .mem_cycle(mem_cycle),
        .mem_addr(mem_addr),
        .bar0_base(bar0_base),
        .bar1_base(bar1_base),
        .vga_graphics_misc_reg(vga_graphics_misc_reg),
        .vga_mem_en(vga_mem_en),
        .mem_bar_hit(mem_bar_hit),
        .mem_vga_hit(mem_vga_hit)
    );

    cfg_vga_io_decode u_io_decode (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .io_space_en(io_space_en),
        .io_cycle(io_cycle),
        .io_addr(io_addr),
        .io_hit(io_hit)
    );

    ////////////////////////////////////////////////////////////////////
    // checks

    serr_gated_a: assert property ( // R1
        @(posedge clk_sys) disable iff (sys_rst)
        !serr_n_oe_n |-> $past(system_error_driver_en) && $past(serr_req))
        else $error("serr driven without enable");

    snoop_bit_a: assert property ( // R2
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_wr && sel_cmd && cfg_be[0] |=>
        palette_snoop_en == $past(cfg_wdata[5]))
        else $error("palette snoop bit not written");

    mwi_gated_a: assert property ( // R3
        @(posedge clk_sys) disable iff (sys_rst)
        master_write_cmd == cfg_pkg::BUS_CMD_MEM_WRITE_INV |->
        $past(mem_write_invalidate_en) && $past(master_wants_mwi))
        else $error("mwi used while disabled");

    master_gated_a: assert property ( // R4
        @(posedge clk_sys) disable iff (sys_rst)
        master_req_out |-> $past(bus_master_en))
        else $error("initiator while master disabled");

    mem_gated_a: assert property ( // R5
        @(posedge clk_sys) disable iff (sys_rst)
        (mem_bar_hit || mem_vga_hit) |->
        $past(mem_space_en) && $past(mem_cycle))
        else $error("memory decode while disabled");

    vga_window_a: assert property ( // R6
        @(posedge clk_sys) disable iff (sys_rst)
        mem_cycle && mem_space_en && vga_mem_en &&
        vga_graphics_misc_reg == 2'b10 &&
        mem_addr[31:15] == 17'h00016 |=> mem_vga_hit)
        else $error("vga window b0000 not decoded");

    io_ports_a: assert property ( // R7
        @(posedge clk_sys) disable iff (sys_rst)
        io_cycle && io_space_en && io_addr[9:0] == 10'h3D4 |=> io_hit)
        else $error("vga io port not decoded");

    io_gated_a: assert property ( // R7
        @(posedge clk_sys) disable iff (sys_rst)
        io_hit |-> $past(io_space_en))
        else $error("io decode while disabled");

    class_read_a: assert property ( // R8 R9 R10
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_rd && sel_rev |=> cfg_rdata[31:8] == 24'h030000 &&
        cfg_rdata[7:0] == SILICON_REVISION)
        else $error("class or revision read wrong");

    reserved_zero_a: assert property ( // R11
        @(posedge clk_sys) disable iff (sys_rst)
        (bus_command_control_q & ~16'h0137) == 16'h0000)
        else $error("reserved command bit set");

    ack_timing_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cfg_rd || cfg_wr) |=> cfg_ack ##1
        (!cfg_ack || $past(cfg_rd) || $past(cfg_wr)))
        else $error("ack timing wrong");

    cmd_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(cfg_wr && sel_cmd) && !sys_rst |=> $stable(bus_command_control_q))
        else $error("command changed without write");

    serr_bit_write_a: assert property ( // R1
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_wr && sel_cmd && cfg_be[1] |=>
        system_error_driver_en == $past(cfg_wdata[8]))
        else $error("system_error_driver_en bit not written");

    low_bits_write_a: assert property ( // R3 R4 R5 R7
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_wr && sel_cmd && cfg_be[0] |=>
        {bus_master_en, mem_space_en, io_space_en} ==
        $past(cfg_wdata[2:0]) &&
        mem_write_invalidate_en == $past(cfg_wdata[4]))
        else $error("low command bits not written");

    serr_follow_a: assert property ( // R1
        @(posedge clk_sys) disable iff (sys_rst)
        serr_req && system_error_driver_en && !sys_rst |=> !serr_n_oe_n)
        else $error("serr not driven while enabled");

    master_follow_a: assert property ( // R4
        @(posedge clk_sys) disable iff (sys_rst)
        master_req && bus_master_en && !sys_rst |=> master_req_out)
        else $error("master request dropped while enabled");

    mwi_follow_a: assert property ( // R3
        @(posedge clk_sys) disable iff (sys_rst)
        master_wants_mwi && mem_write_invalidate_en && !sys_rst |=>
        master_write_cmd == cfg_pkg::BUS_CMD_MEM_WRITE_INV)
        else $error("mwi refused while enabled");

    class_bytes_a: assert property ( // R8
        @(posedge clk_sys) disable iff (sys_rst)
        cfg_rd && sel_rev |=> cfg_rdata[31:24] == 8'h03 &&
        cfg_rdata[23:16] == 8'h00 && cfg_rdata[15:8] == 8'h00)
        else $error("class code bytes misplaced");

    // no disable here: this one must look at the reset itself
    reset_values_a: assert property ( // R1 R2 R3 R4 R5 R7
        @(posedge clk_sys)
        sys_rst |=> bus_command_control_q == 16'h0000 && !cfg_ack &&
        serr_n_oe_n && !master_req_out &&
        master_write_cmd == cfg_pkg::BUS_CMD_MEM_WRITE)
        else $error("outputs not at reset values");

    rdata_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !cfg_rd && !sys_rst |=> $stable(cfg_rdata))
        else $error("read data changed without read");

    serr_cover_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        !serr_n_oe_n);
    mwi_cover_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        master_write_cmd == cfg_pkg::BUS_CMD_MEM_WRITE_INV);
    vga_cover_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        mem_vga_hit ##1 io_hit);
    class_cover_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        cfg_rd && sel_rev ##1 cfg_ack);
    wr_cover_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        cfg_wr && sel_cmd ##1 cfg_ack);
endmodule : pci_config_command_class_rev
`default_nettype wire

// ==== testbench/cfg_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module cfg_host_model (
    input wire logic clk_sys,
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack
);
    initial begin
        cfg_rd = 1'h0;
        cfg_wr = 1'h0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h00000000;
    end

    // one pulse per access, answer is due exactly one cycle later
    task automatic access(input logic wr, input logic [7:0] addr,
            input logic [3:0] be, input logic [31:0] wdata,
            output logic [31:0] rdata, output logic ack_seen);
        @(posedge clk_sys);
        cfg_rd <= !wr;
        cfg_wr <= wr;
        cfg_addr <= addr;
        cfg_be <= be;
        cfg_wdata <= wdata;
        @(posedge clk_sys);
        cfg_rd <= 1'h0;
        cfg_wr <= 1'h0;
        // released byte enables and write data show inverted junk; the address keeps its stale value
        cfg_be <= ~be;
        cfg_wdata <= ~wdata;
        // ack and data are taken at the edge that samples ack high
        @(posedge clk_sys);
        ack_seen = cfg_ack;
        rdata = cfg_rdata;
    endtask : access
endmodule : cfg_host_model

`default_nettype wire

// ==== testbench/pci_config_command_class_rev_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module pci_config_command_class_rev_tb;
    // arbitrary revision value
    localparam logic [7:0] REV = 8'h3C;
    logic clk_sys, sys_rst, serr_req, master_req, master_wants_mwi;
    logic mem_cycle, vga_mem_en, io_cycle;
    logic [31:0] mem_addr;
    logic [7:0] bar0_base, bar1_base;
    logic [1:0] vga_graphics_misc_reg;
    logic [15:0] io_addr;
    logic cfg_rd, cfg_wr, cfg_ack, serr_n_o, serr_n_oe_n;
    logic master_req_out, palette_snoop_en, mem_bar_hit, mem_vga_hit;
    logic io_hit;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be, master_write_cmd;
    logic [31:0] cfg_wdata, cfg_rdata;
    int err_total = 0;
    int compares = 0;
    logic [15:0] io_a [9] = '{16'h03B0, 16'h03BB, 16'h03BC, 16'h03AF,
        16'h03C0, 16'h03DF, 16'h03E0, 16'h13D4, 16'hFBB0};
    logic io_e [9] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
    logic [34:0] mt [11] = '{{32'h000A0000, 2'h0, 1'h1},
        {32'h000BFFFF, 2'h0, 1'h1}, {32'h000C0000, 2'h0, 1'h0},
        {32'h0009FFFF, 2'h0, 1'h0}, {32'h000AFFFF, 2'h1, 1'h1},
        {32'h000B0000, 2'h1, 1'h0}, {32'h000B7FFF, 2'h2, 1'h1},
        {32'h000B8000, 2'h2, 1'h0}, {32'h000B8000, 2'h3, 1'h1},
        {32'h000B7FFF, 2'h3, 1'h0}, {32'h100A0000, 2'h0, 1'h0}};

    cfg_host_model host (.clk_sys(clk_sys), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

    pci_config_command_class_rev #(.SILICON_REVISION(REV)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .serr_req(serr_req), .serr_n_o(serr_n_o),
        .serr_n_oe_n(serr_n_oe_n), .master_req(master_req),
        .master_wants_mwi(master_wants_mwi),
        .master_req_out(master_req_out),
        .master_write_cmd(master_write_cmd),
        .palette_snoop_en(palette_snoop_en), .mem_cycle(mem_cycle),
        .mem_addr(mem_addr), .bar0_base(bar0_base), .bar1_base(bar1_base),
        .vga_graphics_misc_reg(vga_graphics_misc_reg),
        .vga_mem_en(vga_mem_en), .mem_bar_hit(mem_bar_hit),
        .mem_vga_hit(mem_vga_hit), .io_cycle(io_cycle), .io_addr(io_addr),
        .io_hit(io_hit));

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [3:0] be,
            input logic [31:0] d);
        logic [31:0] r;
        logic ack;
        host.access(1'h1, a, be, d, r, ack);
        chk("write ack", 32'h1, {31'h0, ack});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic ack;
        host.access(1'h0, a, 4'hF, 32'h00000000, r, ack);
        chk("read ack", 32'h1, {31'h0, ack});
        chk("read data", exp, r);
    endtask : rd

    // gating outputs are registered, so look one edge after driving
    task automatic gate(input logic s, m, w, exp_oe_n, exp_req,
            input logic [3:0] exp_cmd, input logic exp_snoop);
        @(posedge clk_sys);
        serr_req <= s;
        master_req <= m;
        master_wants_mwi <= w;
        @(posedge clk_sys);
        #1;
        chk("serr_n_oe_n", {31'h0, exp_oe_n}, {31'h0, serr_n_oe_n});
        chk("serr_n_o", 32'h0, {31'h0, serr_n_o});
        chk("master_req_out", {31'h0, exp_req}, {31'h0, master_req_out});
        chk("write cmd", {28'h0, exp_cmd}, {28'h0, master_write_cmd});
        chk("snoop", {31'h0, exp_snoop}, {31'h0, palette_snoop_en});
    endtask : gate

    task automatic probe_io(input logic [15:0] a, input logic exp);
        @(posedge clk_sys);
        io_cycle <= 1'h1;
        io_addr <= a;
        @(posedge clk_sys);
        io_cycle <= 1'h0;
        #1;
        chk("io_hit", {31'h0, exp}, {31'h0, io_hit});
    endtask : probe_io

    task automatic probe_mem(input logic [31:0] a, input logic [1:0] map,
            input logic en, eb, ev);
        @(posedge clk_sys);
        mem_cycle <= 1'h1;
        mem_addr <= a;
        vga_graphics_misc_reg <= map;
        vga_mem_en <= en;
        @(posedge clk_sys);
        mem_cycle <= 1'h0;
        #1;
        chk("mem_bar_hit", {31'h0, eb}, {31'h0, mem_bar_hit});
        chk("mem_vga_hit", {31'h0, ev}, {31'h0, mem_vga_hit});
    endtask : probe_mem

    ////////////////////////////////////////////////////////////////////
    initial begin
        #50000;
        err_total++;
        results();
    end

    initial begin
        {sys_rst, serr_req, master_req, master_wants_mwi} = 4'hF;
        {mem_cycle, io_cycle, vga_mem_en} = 3'h1;
        {mem_addr, io_addr, vga_graphics_misc_reg} = 50'h0;
        bar0_base = 8'h12;
        bar1_base = 8'hE0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(posedge clk_sys);
        rd(8'h04, 32'h00000000);
        gate(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 4'h7, 1'h0);
        probe_io(16'h03C0, 1'h0);
        probe_mem(32'h000A0000, 2'h0, 1'h1, 1'h0, 1'h0);
        rd(8'h08, {24'h030000, REV});
        wr(8'h08, 4'hF, 32'hFFFFFFFF);
        rd(8'h08, {24'h030000, REV});
        wr(8'h04, 4'hF, 32'hFFFFFFFF);
        rd(8'h04, 32'h00000137);
        gate(1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 4'hF, 1'h1);
        gate(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 4'h7, 1'h1);
        for (int i = 0; i < 9; i++) probe_io(io_a[i], io_e[i]);
        for (int i = 0; i < 11; i++) begin
            probe_mem(mt[i][34:3], mt[i][2:1], 1'h1, 1'h0, mt[i][0]);
        end
        probe_mem(32'h000A0000, 2'h0, 1'h0, 1'h0, 1'h0);
        probe_mem(32'h12345678, 2'h0, 1'h1, 1'h1, 1'h0);
        probe_mem(32'hE0FF0000, 2'h0, 1'h1, 1'h1, 1'h0);
        probe_mem(32'h13000000, 2'h0, 1'h1, 1'h0, 1'h0);
        // low byte lane only: bit 8 must survive from the last write
        wr(8'h04, 4'h1, 32'hFFFFFF20);
        rd(8'h04, 32'h00000120);
        gate(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 4'h7, 1'h1);
        probe_io(16'h03D4, 1'h0);
        probe_mem(32'h12000000, 2'h0, 1'h1, 1'h0, 1'h0);
        rd(8'h10, 32'h00000000);
        wr(8'h04, 4'h3, 32'h00000107);
        @(posedge clk_sys);
        sys_rst <= 1'h1;
        @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(posedge clk_sys);
        rd(8'h04, 32'h00000000);
        results();
    end
endmodule : pci_config_command_class_rev_tb

`default_nettype wire
